//--- dv/ob0_config_decode_assertions.sv
`include "ob0_defines.vh"

// ==========================================================
// Port checker
module ob0_checker (
    input wire ref_clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire prog_mode,
    input wire [2:0] resonator_range_select,
    input wire low_power_range,
    input wire external_clock_input,
    input wire port_b_pin4,
    input wire rc_startup_256,
    input wire [12:0] first_block_size,
    input wire write_protect,
    input wire config_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    ready_latency_a: assert property (psel && !penable |-> ##2 pready)
        else $error("pready not two cycles after setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside answer");
    data_guard_a: assert property (pready && paddr == `OB0_OFF_DATA && !prog_mode
        && !$past(prog_mode, 3) |-> pslverr) else $error("data access allowed outside mode");
    data_open_a: assert property (pready && paddr == `OB0_OFF_DATA && !pwrite && prog_mode
        && $past(prog_mode, 3) |-> !pslverr) else $error("data read refused in mode");
    cmd_wp_a: assert property (pready && pwrite && paddr == `OB0_OFF_CMD && write_protect
        |-> pslverr) else $error("erase accepted while write protected");
    decode_hold_a: assert property (config_valid && $past(config_valid)
        |-> $stable({resonator_range_select, first_block_size, write_protect}))
        else $error("decoded fields changed after latch");
    rc_gate_a: assert property (rc_startup_256 |-> resonator_range_select == 3'h0
        && !low_power_range && !port_b_pin4) else $error("range applied with internal source");
    ext_pin_a: assert property (config_valid && !rc_startup_256
        && resonator_range_select == 3'h7 |-> port_b_pin4 && external_clock_input)
        else $error("code seven not decoded to port pin");
    size_map_a: assert property (config_valid |-> first_block_size inside
        {13'h0200, 13'h0400, 13'h0800, 13'h1000}) else $error("illegal block size");
endmodule

bind ob0_config_decode ob0_checker ob0_checker_i (.ref_clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .prog_mode, .resonator_range_select, .low_power_range,
    .external_clock_input, .port_b_pin4, .rc_startup_256, .first_block_size, .write_protect,
    .config_valid);

//--- dv/ob0_config_decode_bench.sv
`include "ob0_defines.vh"

// ==========================================================
// Testbench
module ob0_config_decode_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int n_checks = 0;
    wire psel, penable, pwrite, pready, pslverr, prog_mode, rc_osc_off;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [2:0] resonator_range_select;
    wire [12:0] first_block_size;
    wire low_power_range, external_clock_input, port_b_pin4, range_reserved, rc_startup_256;
    wire readout_protect, write_protect, config_valid;
    wire medium_power_range, medium_speed_range, high_speed_range, watch_crystal_range;
    wire resonator_pin_one, mass_erase;

    initial forever #2.5 ref_clk = ~ref_clk;

    ob0_config_decode ob0_config_decode_i (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .prog_mode, .rc_osc_off, .resonator_range_select,
        .low_power_range, .medium_power_range, .medium_speed_range, .high_speed_range,
        .watch_crystal_range, .external_clock_input, .resonator_pin_one, .port_b_pin4,
        .range_reserved, .rc_startup_256, .first_block_size, .readout_protect, .write_protect,
        .mass_erase, .config_valid);
    ob0_prog_tool ob0_prog_tool_i (.ref_clk, .prdata, .pready, .pslverr, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prog_mode, .rc_osc_off);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Mode pins settle before reset ends so the latch sees synced levels.
    task automatic do_reset(input logic rc_off);
        ob0_prog_tool_i.set_pins(1'b0, rc_off);
        nrst <= 1'b0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic t_blank_decode;
        do_reset(1'b1);
        check(32'(resonator_range_select), 32'h7);
        check({port_b_pin4, low_power_range, external_clock_input, range_reserved}, 4'ha);
        check({medium_power_range, medium_speed_range, high_speed_range, watch_crystal_range,
            resonator_pin_one, mass_erase}, 6'h00);
        check(32'(rc_startup_256), 32'h0);
        check(32'(first_block_size), 32'(`OB0_SIZE_4K));
        check({readout_protect, write_protect, config_valid}, 3'h7);
    endtask

    task automatic t_rc_selected;
        do_reset(1'b0);
        check(32'(resonator_range_select), 32'h0);
        check({port_b_pin4, low_power_range, external_clock_input, rc_startup_256}, 4'h1);
    endtask

    task automatic t_apb_access;
        ob0_prog_tool_i.xfer(1'b0, `OB0_OFF_DATA, 32'h0, rd, er);
        check(32'(er), 32'h1);
        ob0_prog_tool_i.set_pins(1'b1, 1'b1);
        repeat (3) @(posedge ref_clk);
        ob0_prog_tool_i.xfer(1'b0, `OB0_OFF_DATA, 32'h0, rd, er);
        check({rd[7:0], 7'h0, er}, 16'hff00);
        ob0_prog_tool_i.xfer(1'b1, `OB0_OFF_DATA, 32'h0, rd, er);
        check(32'(er), 32'h0);
        ob0_prog_tool_i.xfer(1'b0, `OB0_OFF_DATA, 32'h0, rd, er);
        check(32'(rd[7:0]), 32'hff);
        ob0_prog_tool_i.xfer(1'b1, `OB0_OFF_CMD, 32'h1, rd, er);
        check(32'(er), 32'h1);
        ob0_prog_tool_i.xfer(1'b0, `OB0_OFF_STATUS, 32'h0, rd, er);
        check(32'(rd[2:0]), 32'h7);
        ob0_prog_tool_i.xfer(1'b1, `OB0_OFF_DECODE, 32'h0, rd, er);
        check(32'(er), 32'h1);
        ob0_prog_tool_i.xfer(1'b0, `OB0_OFF_DECODE, 32'h0, rd, er);
        check({rd[26:14], rd[1:0]}, {`OB0_SIZE_4K, 2'h3});
        ob0_prog_tool_i.xfer(1'b0, 12'h010, 32'h0, rd, er);
        check(32'(er), 32'h1);
        check({resonator_range_select, write_protect}, 4'hf);
        ob0_prog_tool_i.set_pins(1'b0, 1'b1);
        repeat (3) @(posedge ref_clk);
        ob0_prog_tool_i.xfer(1'b1, `OB0_OFF_DATA, 32'h0, rd, er);
        check(32'(er), 32'h1);
    endtask

    initial begin
        #20us;
        err_total++;
        end_of_test();
    end

    initial begin
        t_blank_decode();
        t_apb_access();
        t_rc_selected();
        end_of_test();
    end
endmodule

//--- dv/ob0_prog_tool.sv
`include "ob0_defines.vh"

// ==========================================================
// Programming tool model: an APB master with the mode pins
module ob0_prog_tool (
    input wire ref_clk,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [11:0] paddr = 12'h000,
    output logic [31:0] pwdata = 32'h0,
    output logic prog_mode = 1'b0,
    output logic rc_osc_off = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;

    task automatic set_pins(input logic p, input logic r);
        @(posedge ref_clk);
        prog_mode <= p;
        rc_osc_off <= r;
    endtask

    // Only the bench watchdog ends the wait on a silent slave.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= (a == `OB0_OFF_DATA) ? (d | 32'h80 | (rc_osc_off ? 32'h0 : 32'h70)) : d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

//--- src/ob0_config_decode.v
`include "ob0_defines.vh"

// How it works
// - Option byte reads and writes succeed only while programming mode is asserted.
// - Resonator range applies only when the internal RC oscillator is deselected.
// - Range codes select resonator band, external clock pin, or reserved.
// - Blank storage holds all ones; its set bit zero keeps the user from ever programming it.
// - Two-bit sector field selects first block of 0.5, 1, 2 or 4 KB.
// - Bit one enables readout protection; erasing it first erases all memory.
// - Bit zero blocks all later erase and programming, itself included.
module ob0_config_decode (
    input wire ref_clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire prog_mode,
    input wire rc_osc_off,
    output wire [2:0] resonator_range_select,
    output wire low_power_range,
    output wire medium_power_range,
    output wire medium_speed_range,
    output wire high_speed_range,
    output wire watch_crystal_range,
    output wire external_clock_input,
    output wire resonator_pin_one,
    output wire port_b_pin4,
    output wire range_reserved,
    output wire rc_startup_256,
    output wire [12:0] first_block_size,
    output wire readout_protect,
    output wire write_protect,
    output wire mass_erase,
    output wire config_valid
);
    // ==========================================================
    // Declarations
    reg [7:0] nv_byte_ff;
    reg [7:0] nxt_nv_byte;
    reg [1:0] prog_sync_ff;
    reg [1:0] rc_sync_ff;
    reg [1:0] load_cnt_ff;
    reg loaded_ff;
    reg pready_ff;
    reg [31:0] prdata_ff;
    reg pslverr_ff;
    reg [31:0] nxt_prdata;
    reg nxt_pslverr;
    reg mass_erase_ff;
    reg nxt_mass_erase;
    reg [2:0] range_ff;
    reg [7:0] sel_ff;
    reg range_rsv_ff;
    reg rc_start_ff;
    reg [12:0] size_ff;
    reg rdp_ff;
    reg wrp_ff;
    reg [12:0] size_dec;
    wire [7:0] sel_dec;
    wire rsv_dec;
    wire prog_on;
    wire rc_off_s;
    wire setup_phase;
    wire commit;
    wire hit_data;
    wire hit_cmd;
    wire hit_status;
    wire hit_decode;

    // ==========================================================
    // Pin synchronisers
    // Both pins come from outside the clock domain.
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prog_sync_ff <= 2'h0;
            rc_sync_ff <= 2'h0;
        end else begin
            prog_sync_ff <= {prog_sync_ff[0], prog_mode};
            rc_sync_ff <= {rc_sync_ff[0], rc_osc_off};
        end
    end
    assign prog_on = prog_sync_ff[1];
    assign rc_off_s = rc_sync_ff[1];

    // ==========================================================
    // APB decode
    // One wait state lets every answer come from a flip-flop.
    assign setup_phase = psel & penable & ~pready_ff;
    assign commit = psel & penable & pready_ff;
    assign hit_data = (paddr == `OB0_OFF_DATA);
    assign hit_cmd = (paddr == `OB0_OFF_CMD);
    assign hit_status = (paddr == `OB0_OFF_STATUS);
    assign hit_decode = (paddr == `OB0_OFF_DECODE);

    always @* begin
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        if (hit_data) begin
            if (!prog_on) begin
                nxt_pslverr = 1'b1;
            end else if (!pwrite) begin
                nxt_prdata = {24'h00_0000, nv_byte_ff};
            end
        end else if (hit_cmd) begin
            if (!prog_on || wrp_byte_blocked(nv_byte_ff)) begin
                nxt_pslverr = pwrite;
            end
        end else if (hit_status) begin
            nxt_pslverr = pwrite;
            nxt_prdata = {29'h0000_0000, loaded_ff, rc_off_s, prog_on};
        end else if (hit_decode) begin
            nxt_pslverr = pwrite;
            nxt_prdata = {5'h00, size_ff, rc_start_ff, range_rsv_ff, sel_ff[6:0],
                range_ff, rdp_ff, wrp_ff};
        end else begin
            nxt_pslverr = 1'b1;
        end
    end

    function wrp_byte_blocked;
        input [7:0] b;
        begin
            wrp_byte_blocked = b[`OB0_WRP_BIT];
        end
    endfunction

    // ==========================================================
    // Non-volatile option byte
    always @* begin
        nxt_nv_byte = nv_byte_ff;
        nxt_mass_erase = 1'b0;
        // Programming is locked for good once write protection is set.
        if (commit && pwrite && prog_on && !nv_byte_ff[`OB0_WRP_BIT]) begin
            if (hit_data) begin
                // The reserved bit is stored as given; the tool must send one.
                nxt_nv_byte = pwdata[7:0];
            end else if (hit_cmd && pwdata[`OB0_CMD_ERASE_BIT]) begin
                nxt_nv_byte = `OB0_BLANK;
                nxt_mass_erase = nv_byte_ff[`OB0_RDP_BIT];
            end
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
            mass_erase_ff <= 1'b0;
        end else begin
            pready_ff <= setup_phase;
            prdata_ff <= setup_phase ? nxt_prdata : 32'h0000_0000;
            pslverr_ff <= setup_phase ? nxt_pslverr : 1'b0;
            mass_erase_ff <= nxt_mass_erase;
        end
    end

    // The flip-flop model of the cell starts blank after power-up reset.
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            nv_byte_ff <= `OB0_BLANK;
        end else begin
            nv_byte_ff <= nxt_nv_byte;
        end
    end

    // ==========================================================
    // Decode and latch
    ob0_range_decode ob0_range_decode_i (
        .code(nv_byte_ff[`OB0_RANGE_HI:`OB0_RANGE_LO]),
        .rc_off(rc_off_s),
        .sel_onehot(sel_dec),
        .range_reserved(rsv_dec)
    );

    always @* begin
        case (nv_byte_ff[`OB0_SEC_HI:`OB0_SEC_LO])
            2'h0: size_dec = `OB0_SIZE_HALF_K;
            2'h1: size_dec = `OB0_SIZE_1K;
            2'h2: size_dec = `OB0_SIZE_2K;
            default: size_dec = `OB0_SIZE_4K;
        endcase
    end

    // Capture waits for the RC select pin to clear its synchroniser.
    // Changes made while programming never show here: the next reset returns the byte to blank before the capture.
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            load_cnt_ff <= 2'h0;
            loaded_ff <= 1'b0;
            range_ff <= 3'h0;
            sel_ff <= 8'h00;
            range_rsv_ff <= 1'b0;
            rc_start_ff <= 1'b0;
            size_ff <= 13'h0000;
            rdp_ff <= 1'b0;
            wrp_ff <= 1'b0;
        end else if (!loaded_ff) begin
            load_cnt_ff <= load_cnt_ff + 2'h1;
            if (load_cnt_ff == `OB0_LOAD_WAIT) begin
                loaded_ff <= 1'b1;
                range_ff <= rc_off_s ? nv_byte_ff[`OB0_RANGE_HI:`OB0_RANGE_LO] : 3'h0;
                sel_ff <= sel_dec;
                range_rsv_ff <= rsv_dec;
                rc_start_ff <= ~rc_off_s;
                size_ff <= size_dec;
                rdp_ff <= nv_byte_ff[`OB0_RDP_BIT];
                wrp_ff <= nv_byte_ff[`OB0_WRP_BIT];
            end
        end
    end

    // ==========================================================
    // Outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign resonator_range_select = range_ff;
    assign low_power_range = sel_ff[0];
    assign medium_power_range = sel_ff[1];
    assign medium_speed_range = sel_ff[2];
    assign high_speed_range = sel_ff[3];
    assign watch_crystal_range = sel_ff[4];
    assign resonator_pin_one = sel_ff[5];
    assign port_b_pin4 = sel_ff[6];
    assign external_clock_input = sel_ff[7];
    assign range_reserved = range_rsv_ff;
    assign rc_startup_256 = rc_start_ff;
    assign first_block_size = size_ff;
    assign readout_protect = rdp_ff;
    assign write_protect = wrp_ff;
    assign mass_erase = mass_erase_ff;
    assign config_valid = loaded_ff;
endmodule

//--- src/ob0_defines.vh
`ifndef OB0_DEFINES_VH
`define OB0_DEFINES_VH

// ==========================================================
// Register offsets
`define OB0_OFF_DATA 12'h000
`define OB0_OFF_CMD 12'h004
`define OB0_OFF_STATUS 12'h008
`define OB0_OFF_DECODE 12'h00c

// ==========================================================
// Option byte field positions
`define OB0_RSV_BIT 7
`define OB0_RANGE_HI 6
`define OB0_RANGE_LO 4
`define OB0_SEC_HI 3
`define OB0_SEC_LO 2
`define OB0_RDP_BIT 1
`define OB0_WRP_BIT 0

// ==========================================================
// Command register bits
`define OB0_CMD_ERASE_BIT 0

// ==========================================================
// Values
`define OB0_BLANK 8'hff
`define OB0_RANGE_LP 3'h0
`define OB0_RANGE_MP 3'h1
`define OB0_RANGE_MS 3'h2
`define OB0_RANGE_HS 3'h3
`define OB0_RANGE_VLP 3'h4
`define OB0_RANGE_EXT_OSC 3'h5
`define OB0_RANGE_RSV 3'h6
`define OB0_RANGE_EXT_PB4 3'h7
`define OB0_SIZE_HALF_K 13'h0200
`define OB0_SIZE_1K 13'h0400
`define OB0_SIZE_2K 13'h0800
`define OB0_SIZE_4K 13'h1000
`define OB0_RC_STARTUP 9'h100

// ==========================================================
// Timing
`define OB0_LOAD_WAIT 2'h3

`endif

//--- src/ob0_range_decode.v
`include "ob0_defines.vh"

// ==========================================================
// Resonator range decoder
module ob0_range_decode (
    input wire [2:0] code,
    input wire rc_off,
    output reg [7:0] sel_onehot,
    output reg range_reserved
);
    always @* begin
        sel_onehot = 8'h00;
        range_reserved = 1'b0;
        // With the internal RC selected the field carries no meaning.
        if (rc_off) begin
            case (code)
                `OB0_RANGE_LP: sel_onehot = 8'h01;
                `OB0_RANGE_MP: sel_onehot = 8'h02;
                `OB0_RANGE_MS: sel_onehot = 8'h04;
                `OB0_RANGE_HS: sel_onehot = 8'h08;
                `OB0_RANGE_VLP: sel_onehot = 8'h10;
                // Bit 7 flags an external clock on either pin.
                `OB0_RANGE_EXT_OSC: sel_onehot = 8'ha0;
                `OB0_RANGE_EXT_PB4: sel_onehot = 8'hc0;
                default: range_reserved = 1'b1;
            endcase
        end
    end
endmodule
